// file: src/wps_sequencer.sv
// power-mode sequencer: host command decode, power gating state machine
`timescale 1ns/10ps
module wps_sequencer #(
  parameter int SLEEP_UNIT_CYCLES = wps_pkg::SLEEP_UNIT_CYC, // cycles per sleep unit
  parameter int SLEEP_W = 6 // width of the sleep interval
) (
  input wire logic clk, // 25 mhz system clock
  input wire logic rst, // synchronous reset, high
  input wire wps_pkg::wps_spi_in_s spi_i, // host spi pins
  input wire wps_pkg::wps_link_s link_i, // connection and beacon events
  output logic spi_miso, // serial data to host
  output logic spi_miso_oe, // high while driving miso
  output wps_pkg::wps_pwr_s pwr_o, // power enables, high = powered
  output logic sleep_req, // level: asking host for core shutdown
  output logic [1:0] mode, // current power mode
  output logic cmd_reject // pulse: invalid mode request dropped
);
  import wps_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (SLEEP_UNIT_CYCLES < 2) begin : g_chk_unit
    $error("SLEEP_UNIT_CYCLES must be at least 2");
  end
  if (SLEEP_W < 1 || SLEEP_W > CMD_ARG_MSB + 1) begin : g_chk_w
    $error("SLEEP_W must fit the command argument field");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  wps_state_e st_q, st_d;
  wps_pwr_s pwr_q, pwr_d;
  logic [1:0] mode_q, mode_d;
  logic [SLEEP_W-1:0] int_q, int_d;
  logic req_q, req_d;
  logic rej_q, rej_d;
  logic grant_q, grant_d;
  logic tmr_start;
  logic tmr_expire;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic [7:0] status_byte;
  logic [1:0] cmd_op;
  logic [5:0] cmd_arg;
  logic quiet;
  logic link_up;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // power pattern belonging to each state
  function automatic wps_pwr_s pwr_of(input wps_state_e s);
    wps_pwr_s p;
    p = PWR_ALL_ON;
    unique case (s)
      ST_ON: begin
        p = PWR_ALL_ON;
      end
      ST_RADIO_OFF, ST_REQ: begin
        p = '{bb: 1'b0, rf: 1'b0, core: 1'b1};
      end
      ST_SLEEP: begin
        p = '{bb: 1'b0, rf: 1'b0, core: 1'b0};
      end
      default: begin
        p = PWR_ALL_ON;
      end
    endcase
    return p;
  endfunction : pwr_of

  // mode argument must name 0, 1 or 2
  function automatic logic mode_ok(input logic [5:0] arg);
    return arg < MODE_ARG_LIMIT;
  endfunction : mode_ok

  // ----------------------------------------------------------------
  // host link
  // ----------------------------------------------------------------
  // pins are oversampled, so in practice sclk must stay well below clk/4
  wps_spi_slave u_spi (
    .clk(clk),
    .rst(rst),
    .spi_i(spi_i),
    .tx_byte(status_byte),
    .miso(spi_miso),
    .miso_oe(spi_miso_oe),
    .rx_byte(rx_byte),
    .rx_valid(rx_valid)
  );

  // status returned to the host on every transfer
  assign status_byte = {req_q, pwr_q.core, pwr_q.rf, pwr_q.bb, link_i.connected,
                        1'b0, mode_q};

  assign cmd_op = rx_byte[CMD_OP_MSB:CMD_OP_LSB];
  assign cmd_arg = rx_byte[CMD_ARG_MSB:CMD_ARG_LSB];

  // ----------------------------------------------------------------
  // command decode: mode, interval, grant
  // ----------------------------------------------------------------
  // mode and interval are stored even while asleep; the state machine
  // acts on them at the next wake, since the host is silent then anyway
  always_comb begin
    mode_d = mode_q;
    int_d = int_q;
    rej_d = 1'b0;
    grant_d = 1'b0;
    if (rx_valid) begin
      unique case (cmd_op)
        OP_SET_MODE: begin
          if (mode_ok(cmd_arg)) begin
            mode_d = cmd_arg[1:0];
          end else begin
            rej_d = 1'b1;
          end
        end
        OP_GRANT: begin
          grant_d = 1'b1;
        end
        OP_SET_SLEEP: begin
          int_d = cmd_arg[SLEEP_W-1:0];
        end
        OP_NOP: begin
          rej_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= MODE_RESET;
      int_q <= SLEEP_INT_RESET[SLEEP_W-1:0];
      rej_q <= 1'b0;
      grant_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      int_q <= int_d;
      rej_q <= rej_d;
      grant_q <= grant_d;
    end
  end

  // ----------------------------------------------------------------
  // sleep timer
  // ----------------------------------------------------------------
  // started on a grant in the request state of mode 1 only; a stale expiry outside sleep is ignored
  assign tmr_start = (st_q == ST_REQ) && grant_q && (mode_q == MODE_DEEP);

  wps_sleep_timer #(
    .UNIT_CYC(SLEEP_UNIT_CYCLES),
    .INT_W(SLEEP_W)
  ) u_tmr (
    .clk(clk),
    .rst(rst),
    .start(tmr_start),
    .interval(int_q),
    .expire(tmr_expire)
  );

  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  // beacon checked and nothing buffered at the ap nor queued locally
  assign quiet = link_i.beacon_seen & ~link_i.beacon_buffered & ~link_i.traffic_pending;
  assign link_up = link_i.connected;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_ON: begin
        if (mode_q == MODE_DEEP) begin
          if (!link_up) begin
            st_d = ST_RADIO_OFF;
          end else if (quiet) begin
            st_d = ST_RADIO_OFF;
          end
        end else if (mode_q == MODE_LIGHT) begin
          if (!link_up) begin
            st_d = ST_RADIO_OFF;
          end else if (quiet) begin
            st_d = ST_RADIO_OFF;
          end
        end
      end
      ST_RADIO_OFF: begin
        // radio is gated first, the core request follows a cycle later
        if (mode_q == MODE_FULL) begin
          st_d = ST_ON;
        end else if (mode_q == MODE_DEEP) begin
          st_d = ST_REQ;
        end else if (link_up && (link_i.beacon_wake || link_i.traffic_pending)) begin
          st_d = ST_ON;
        end
        // mode 2 without a link stays here until mode 0 or mode 1
      end
      ST_REQ: begin
        if (mode_q == MODE_FULL) begin
          st_d = ST_ON;
        end else if (mode_q == MODE_LIGHT) begin
          st_d = ST_RADIO_OFF;
        end else if (grant_q) begin
          st_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (link_up) begin
          if (link_i.beacon_wake) begin
            st_d = ST_ON;
          end
        end else if (tmr_expire) begin
          st_d = ST_REQ;
        end
      end
      default: begin
        st_d = ST_ON;
      end
    endcase
  end

  // outputs follow the next state so each enable is a plain flop
  always_comb begin
    pwr_d = pwr_of(st_d);
    req_d = (st_d == ST_REQ);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= ST_ON;
      pwr_q <= PWR_ALL_ON;
      req_q <= 1'b0;
    end else begin
      st_q <= st_d;
      pwr_q <= pwr_d;
      req_q <= req_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pwr_o = pwr_q;
  assign sleep_req = req_q;
  assign mode = mode_q;
  assign cmd_reject = rej_q;

endmodule : wps_sequencer

// file: pkg/wps_pkg.sv
// package: constants, structs and state codes for the power-mode sequencer
package wps_pkg;

  // ----------------------------------------------------------------
  // clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int SPI_MAX_MHZ = 25;
  localparam int SLEEP_UNIT_US = 1000;
  localparam int SLEEP_UNIT_CYC = (SLEEP_UNIT_US * 1000) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // power modes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_FULL = 2'h0;
  localparam logic [1:0] MODE_DEEP = 2'h1;
  localparam logic [1:0] MODE_LIGHT = 2'h2;
  localparam logic [1:0] MODE_RESET = MODE_FULL;

  // ----------------------------------------------------------------
  // host command byte layout: opcode in [7:6], argument in [5:0]
  // ----------------------------------------------------------------
  localparam int CMD_OP_MSB = 7;
  localparam int CMD_OP_LSB = 6;
  localparam int CMD_ARG_MSB = 5;
  localparam int CMD_ARG_LSB = 0;
  localparam logic [1:0] OP_SET_MODE = 2'h0;
  localparam logic [1:0] OP_GRANT = 2'h1;
  localparam logic [1:0] OP_SET_SLEEP = 2'h2;
  localparam logic [1:0] OP_NOP = 2'h3;
  localparam logic [5:0] MODE_ARG_LIMIT = 6'h03;
  localparam logic [5:0] SLEEP_INT_RESET = 6'h0A;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic bb;
    logic rf;
    logic core;
  } wps_pwr_s;

  localparam wps_pwr_s PWR_ALL_ON = 3'h7;

  typedef struct packed {
    logic connected;
    logic traffic_pending;
    logic beacon_wake;
    logic beacon_seen;
    logic beacon_buffered;
  } wps_link_s;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
  } wps_spi_in_s;

  localparam wps_spi_in_s SPI_IDLE = 3'h2;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_ON        = 4'h1,
    ST_RADIO_OFF = 4'h2,
    ST_REQ       = 4'h4,
    ST_SLEEP     = 4'h8
  } wps_state_e;

endpackage : wps_pkg

// file: src/wps_spi_slave.sv
// spi mode-0 slave: byte receive on mosi, status byte out on miso
`timescale 1ns/10ps
module wps_spi_slave (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset, high
  input wire wps_pkg::wps_spi_in_s spi_i, // raw pins from the host
  input wire logic [7:0] tx_byte, // status sent on each frame
  output logic miso, // serial data to host
  output logic miso_oe, // high while driving miso
  output logic [7:0] rx_byte, // last received byte
  output logic rx_valid // one-cycle pulse per byte
);
  import wps_pkg::*;

  wps_spi_in_s s1_q, s2_q, s3_q;
  logic [7:0] sh_q, sh_d, tx_q, tx_d, rx_q, rx_d;
  logic [2:0] cnt_q, cnt_d;
  logic vld_q, vld_d, miso_q, miso_d, oe_q, oe_d;
  logic rise, fall, start;

  // edges are taken between the second and third stages only
  assign rise = s2_q.sclk & ~s3_q.sclk & ~s2_q.cs_n;
  assign fall = ~s2_q.sclk & s3_q.sclk & ~s2_q.cs_n;
  assign start = ~s2_q.cs_n & s3_q.cs_n;

  // ----------------------------------------------------------------
  // shift logic, msb first
  // ----------------------------------------------------------------
  always_comb begin
    sh_d = sh_q;
    tx_d = tx_q;
    rx_d = rx_q;
    cnt_d = cnt_q;
    vld_d = 1'b0;
    miso_d = miso_q;
    oe_d = ~s2_q.cs_n;
    if (s2_q.cs_n) begin
      cnt_d = 3'h0;
    end else if (start) begin
      tx_d = {tx_byte[6:0], 1'b0};
      miso_d = tx_byte[7];
      cnt_d = 3'h0;
    end else begin
      if (rise) begin
        sh_d = {sh_q[6:0], s2_q.mosi};
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == 3'h7) begin
          rx_d = {sh_q[6:0], s2_q.mosi};
          vld_d = 1'b1;
        end
      end
      if (fall) begin
        // reload the status at each byte boundary
        miso_d = (cnt_q == 3'h0) ? tx_byte[7] : tx_q[7];
        tx_d = (cnt_q == 3'h0) ? {tx_byte[6:0], 1'b0} : {tx_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= SPI_IDLE;
      s2_q <= SPI_IDLE;
      s3_q <= SPI_IDLE;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      cnt_q <= 3'h0;
      vld_q <= 1'b0;
      miso_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      s1_q <= spi_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      sh_q <= sh_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      cnt_q <= cnt_d;
      vld_q <= vld_d;
      miso_q <= miso_d;
      oe_q <= oe_d;
    end
  end

  assign miso = miso_q;
  assign miso_oe = oe_q;
  assign rx_byte = rx_q;
  assign rx_valid = vld_q;

endmodule : wps_spi_slave

// file: src/wps_sleep_timer.sv
// sleep interval timer: counts whole units, pulses once on expiry
`timescale 1ns/10ps
module wps_sleep_timer #(
  parameter int UNIT_CYC = 25000, // clock cycles per interval unit
  parameter int INT_W = 6 // width of the interval count
) (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset, high
  input wire logic start, // pulse: (re)load and run
  input wire logic [INT_W-1:0] interval, // units to wait, 0 taken as 1
  output logic expire // one-cycle pulse at the end
);
  localparam int PW = (UNIT_CYC > 1) ? $clog2(UNIT_CYC) : 1;
  localparam logic [PW-1:0] PRE_LOAD = PW'(UNIT_CYC - 1);

  if (UNIT_CYC < 2 || INT_W < 1) begin : g_chk
    $error("sleep timer needs UNIT_CYC >= 2 and INT_W >= 1");
  end

  logic run_q, run_d, exp_q, exp_d;
  logic [PW-1:0] pre_q, pre_d;
  logic [INT_W-1:0] units_q, units_d;

  // ----------------------------------------------------------------
  // prescaler and unit countdown
  // ----------------------------------------------------------------
  always_comb begin
    run_d = run_q;
    pre_d = pre_q;
    units_d = units_q;
    exp_d = 1'b0;
    if (start) begin
      run_d = 1'b1;
      pre_d = PRE_LOAD;
      units_d = (interval == '0) ? INT_W'(1) : interval;
    end else if (run_q) begin
      if (pre_q != '0) begin
        pre_d = pre_q - PW'(1);
      end else if (units_q == INT_W'(1)) begin
        run_d = 1'b0;
        exp_d = 1'b1;
      end else begin
        pre_d = PRE_LOAD;
        units_d = units_q - INT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      run_q <= 1'b0;
      pre_q <= '0;
      units_q <= '0;
      exp_q <= 1'b0;
    end else begin
      run_q <= run_d;
      pre_q <= pre_d;
      units_q <= units_d;
      exp_q <= exp_d;
    end
  end

  assign expire = exp_q;

endmodule : wps_sleep_timer

// file: verification/wps_sva.sv
// checker: power sequencing assertions on the sequencer ports
`timescale 1ns/10ps
module wps_sva (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset, high
  input wire wps_pkg::wps_spi_in_s spi_i, // host spi pins
  input wire wps_pkg::wps_link_s link_i, // link events
  input wire logic spi_miso, // serial data to host
  input wire logic spi_miso_oe, // miso drive enable
  input wire wps_pkg::wps_pwr_s pwr_o, // power enables
  input wire logic sleep_req, // shutdown request
  input wire logic [1:0] mode, // current mode
  input wire logic cmd_reject // dropped request pulse
);
  import wps_pkg::*;
  // ----
  // one clock domain, so clocking and disable are shared
  // ----
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_reset_all_on: assert property ($fell(rst) |-> pwr_o == PWR_ALL_ON && mode == MODE_FULL
    && !sleep_req && !cmd_reject) else $error("outputs wrong after reset");
  a_full_all_on: assert property ((mode == MODE_FULL && pwr_o.core) [*5] |->
    pwr_o == PWR_ALL_ON) else $error("mode 0 not fully powered");
  a_mode_legal: assert property (mode != 2'h3)
    else $error("illegal mode reached");
  a_reject_hold: assert property (cmd_reject |-> $stable(mode))
    else $error("mode moved on a dropped request");
  a_core_grant: assert property ($fell(pwr_o.core) |-> $past(sleep_req) && mode == MODE_DEEP)
    else $error("core cut without request or outside mode 1");
  a_core_off_radio: assert property (!pwr_o.core |-> !pwr_o.bb && !pwr_o.rf)
    else $error("radio powered while core off");
  a_req_radio_off: assert property (sleep_req |-> !pwr_o.bb && !pwr_o.rf)
    else $error("request raised with radio on");
  a_timer_rereq: assert property ($rose(pwr_o.core) && !link_i.connected |-> sleep_req)
    else $error("timer wake without new request");
  a_beacon_wake: assert property (!pwr_o.core && link_i.connected && link_i.beacon_wake
    |=> pwr_o == PWR_ALL_ON) else $error("no wake for beacon");
  // oe trails cs_n through the synchronisers, so allow five cycles
  a_oe_idle: assert property (spi_i.cs_n [*5] |-> !spi_miso_oe)
    else $error("miso driven while deselected");
endmodule : wps_sva

bind wps_sequencer wps_sva u_sva (.clk(clk), .rst(rst), .spi_i(spi_i), .link_i(link_i),
  .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .pwr_o(pwr_o), .sleep_req(sleep_req),
  .mode(mode), .cmd_reject(cmd_reject));

// file: verification/wps_host_model.sv
// host model: spi master that frames command bytes and reads status
`timescale 1ns/10ps
module wps_host_model (
  input wire logic clk, // system clock
  input wire logic miso, // serial data from device
  input wire logic miso_oe, // device drives miso
  output wps_pkg::wps_spi_in_s spi_o // pins to the device
);
  import wps_pkg::*;
  // ----
  // idle: sclk parked low, cs_n high
  // ----
  initial begin
    spi_o = SPI_IDLE;
  end
  // halves of 5 and 4 clocks keep sclk well under 25 mhz and the sync delay
  task automatic xfer(input logic [7:0] b, output logic [7:0] st);
    st = 8'h00;
    spi_o.cs_n = 1'b0;
    repeat (6) @(negedge clk);
    for (int i = 7; i >= 0; i--) begin
      spi_o.mosi = b[i];
      repeat (5) @(negedge clk);
      st[i] = miso_oe ? miso : 1'bx;
      spi_o.sclk = 1'b1;
      repeat (4) @(negedge clk);
      spi_o.sclk = 1'b0;
    end
    repeat (4) @(negedge clk);
    spi_o.cs_n = 1'b1;
    spi_o.mosi = ~spi_o.mosi; // released line shows no stale bit
    repeat (4) @(negedge clk);
  endtask : xfer
endmodule : wps_host_model

// file: verification/testbench.sv
// testbench: host commands and link events against the power enables
`timescale 1ns/10ps
module testbench;
  import wps_pkg::*;
  localparam int UNIT = 8;
  logic clk;
  logic rst;
  wps_spi_in_s spi;
  wps_link_s link;
  logic miso;
  logic miso_oe;
  wps_pwr_s pwr;
  logic sleep_req;
  logic [1:0] mode;
  logic cmd_reject;
  logic [7:0] st;
  int failures;
  int n_checks;
  int n_rej;
  int n_off;

  wps_sequencer #(.SLEEP_UNIT_CYCLES(UNIT), .SLEEP_W(6)) uut (.clk(clk), .rst(rst),
    .spi_i(spi), .link_i(link), .spi_miso(miso), .spi_miso_oe(miso_oe), .pwr_o(pwr),
    .sleep_req(sleep_req), .mode(mode), .cmd_reject(cmd_reject));
  wps_host_model u_host (.clk(clk), .miso(miso), .miso_oe(miso_oe), .spi_o(spi));

  // ----
  // clock, reject counter, shared tasks
  // ----
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // core-off cycles are counted here: a short sleep begins inside the grant transfer
  always @(posedge clk) begin
    if (cmd_reject === 1'b1) n_rej++;
    if (pwr.core === 1'b0) n_off++;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic send(input logic [7:0] b);
    u_host.xfer(b, st);
    repeat (8) @(negedge clk);
  endtask : send
  // bounded wait on core enable or on the request level
  task automatic wait_for(input bit core_sig, input logic lvl, output int n);
    n = 0;
    while (((core_sig ? pwr.core : sleep_req) !== lvl) && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n >= 400) check("wait", 8'h00, 8'h01);
  endtask : wait_for
  task automatic beacon(input logic wake, input logic buffered);
    link.beacon_wake = wake;
    link.beacon_seen = !wake;
    link.beacon_buffered = buffered;
    @(negedge clk);
    link.beacon_wake = 1'b0;
    link.beacon_seen = 1'b0;
    link.beacon_buffered = 1'b0;
  endtask : beacon
  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  // ----
  // scenarios
  // ----
  task automatic t_reject();
    n_rej = 0;
    send(8'h03);
    send(8'h3F);
    check("rejects", n_rej[7:0], 8'h02);
    check("mode", {6'h00, mode}, {6'h00, MODE_FULL});
    send(8'hC0);
    check("status mode", {6'h00, st[1:0]}, {6'h00, MODE_FULL});
    check("status pwr", {5'h00, st[6:4]}, 8'h07);
    $display("test reject done");
  endtask : t_reject
  // unconnected mode 1: grant, timer wake, second grant, back to mode 0
  task automatic t_deep_unconn();
    int n;
    send(8'h81);
    send(8'h01);
    wait_for(0, 1'b1, n);
    check("pwr req", {5'h00, pwr}, 8'h01);
    n_off = 0;
    u_host.xfer(8'h40, st);
    wait_for(1, 1'b0, n);
    check("pwr sleep", {5'h00, pwr, sleep_req}, 8'h00);
    wait_for(1, 1'b1, n);
    check("wake time", {7'h00, n_off >= UNIT && n_off <= UNIT + 3}, 8'h01);
    check("re req", {7'h00, sleep_req}, 8'h01);
    n_off = 0;
    u_host.xfer(8'h40, st);
    wait_for(1, 1'b0, n);
    check("resleep", {5'h00, pwr}, 8'h00);
    wait_for(1, 1'b1, n);
    check("resleep time", {7'h00, n_off >= UNIT && n_off <= UNIT + 3}, 8'h01);
    send(8'h00);
    check("pwr full", {5'h00, pwr, sleep_req}, 8'h0E);
    $display("test deep unconnected done");
  endtask : t_deep_unconn
  task automatic t_deep_conn();
    int n;
    link.connected = 1'b1;
    send(8'h01);
    beacon(1'b0, 1'b1);
    repeat (4) @(negedge clk);
    check("busy beacon", {5'h00, pwr}, 8'h07);
    beacon(1'b0, 1'b0);
    wait_for(0, 1'b1, n);
    check("pwr req", {5'h00, pwr}, 8'h01);
    u_host.xfer(8'h40, st);
    wait_for(1, 1'b0, n);
    repeat (3 * UNIT) @(negedge clk);
    check("asleep", {5'h00, pwr}, 8'h00);
    beacon(1'b1, 1'b0);
    repeat (2) @(negedge clk);
    check("beacon wake", {5'h00, pwr}, 8'h07);
    send(8'h00);
    link.connected = 1'b0;
    $display("test deep connected done");
  endtask : t_deep_conn
  task automatic t_light();
    send(8'h02);
    repeat (20) @(negedge clk);
    check("light unconn", {5'h00, pwr}, 8'h01);
    send(8'h00);
    check("back full", {5'h00, pwr}, 8'h07);
    // join happens in mode 0, mode 2 only once connected
    link.connected = 1'b1;
    send(8'h02);
    check("light wait", {5'h00, pwr}, 8'h07);
    beacon(1'b0, 1'b0);
    repeat (4) @(negedge clk);
    check("light quiet", {5'h00, pwr}, 8'h01);
    link.traffic_pending = 1'b1;
    repeat (4) @(negedge clk);
    check("light busy", {5'h00, pwr}, 8'h07);
    link.traffic_pending = 1'b0;
    send(8'h00);
    link.connected = 1'b0;
    $display("test light done");
  endtask : t_light

  // main sequence; reset held three cycles with pins idle
  initial begin
    failures = 0;
    n_checks = 0;
    n_rej = 0;
    link = '0;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check("pwr", {5'h00, pwr}, {5'h00, PWR_ALL_ON});
    check("mode", {6'h00, mode}, {6'h00, MODE_FULL});
    $display("test reset done");
    t_reject();
    t_deep_unconn();
    t_deep_conn();
    t_light();
    print_verdict();
  end
  // watchdog well beyond the 1500 or so cycles the tests need
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule : testbench
